// *** core/pmc_host.sv ***
// host end: software command port, configuration sequencer, pin drive for clock and trigger
module pmc_host (
	input  wire logic  ref_clk_i,
	input  wire logic  nrst_i,
	input  wire logic  clk_en_i,
	pmc_if.host        bus,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       we_i,
	input  wire logic       re_i,
	output logic [7:0] rdata_o,
	output logic       busy_o
);
	typedef enum logic [1:0] {PMC_IDLE, PMC_SEQ} pmc_state_e;
	pmc_state_e state_reg;
	logic [2:0] step_reg;
	logic [1:0] cmd_reg;
	logic [7:0] waddr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] clk_div_reg;
	logic       awake_meta;
	logic       awake_sync;
	logic [7:0] seq_addr;
	logic [7:0] seq_data;
	logic       seq_last;
	logic       pins_free;

	// ----------------------------------------
	// sequences, written in ascending address order
	// ----------------------------------------
	always_comb begin
		seq_addr = waddr_reg;
		seq_data = wdata_reg;
		seq_last = 1'b1;
		case (cmd_reg)
			pmc_pkg::CMD_SWITCH: begin
				seq_last = (step_reg == 3'h6);
				case (step_reg)
					3'h0: begin seq_addr = pmc_pkg::ADDR_THRESH_ACT_LOW;  seq_data = pmc_pkg::MS_THRESH_ACT_LOW; end
					3'h1: begin seq_addr = pmc_pkg::ADDR_THRESH_ACT_HIGH; seq_data = pmc_pkg::MS_THRESH_ZERO; end
					3'h2: begin seq_addr = pmc_pkg::ADDR_ACTIVITY_TIME_COUNT;        seq_data = pmc_pkg::MS_ACTIVITY_TIME_COUNT; end
					3'h3: begin seq_addr = pmc_pkg::ADDR_TIME_INACT;      seq_data = pmc_pkg::MS_TIME_INACT; end
					3'h4: begin seq_addr = pmc_pkg::ADDR_MOTION_DETECT;   seq_data = pmc_pkg::MS_MOTION_DETECT; end
					3'h5: begin seq_addr = pmc_pkg::ADDR_IRQ_MAP_TWO;     seq_data = pmc_pkg::MS_IRQ_MAP_TWO; end
					default: begin seq_addr = pmc_pkg::ADDR_POWER_CONTROL; seq_data = pmc_pkg::MS_POWER_CONTROL; end
				endcase
			end
			pmc_pkg::CMD_EXTCLK: begin
				seq_addr = pmc_pkg::ADDR_POWER_CONTROL;
				seq_data = pmc_pkg::EXT_CLOCK_START;
			end
			pmc_pkg::CMD_EXTTRIG: begin
				seq_addr = pmc_pkg::ADDR_RANGE_RATE;
				seq_data = pmc_pkg::EXT_TRIGGER_SETUP;
			end
			default: begin
			end
		endcase
	end

	// ----------------------------------------
	// command port and sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_reg <= PMC_IDLE;
			step_reg  <= 3'h0;
			cmd_reg   <= pmc_pkg::CMD_SINGLE;
			waddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			bus.cfg_we    <= 1'b0;
			bus.cfg_addr  <= 8'h00;
			bus.cfg_wdata <= 8'h00;
		end else if (clk_en_i) begin
			bus.cfg_we <= 1'b0;
			case (state_reg)
				PMC_IDLE: begin
					if (we_i && addr_i == pmc_pkg::HOST_WADDR) begin
						waddr_reg <= wdata_i;
					end
					// reserved codes are the caller's to avoid; the port passes them on
					if (we_i && addr_i == pmc_pkg::HOST_WDATA) begin
						wdata_reg <= wdata_i;
					end
					if (we_i && addr_i == pmc_pkg::HOST_CMD) begin
						cmd_reg   <= wdata_i[1:0];
						step_reg  <= 3'h0;
						state_reg <= PMC_SEQ;
					end
				end
				PMC_SEQ: begin
					bus.cfg_we    <= 1'b1;
					bus.cfg_addr  <= seq_addr;
					bus.cfg_wdata <= seq_data;
					step_reg      <= step_reg + 3'h1;
					if (seq_last) begin
						state_reg <= PMC_IDLE;
					end
				end
				default: state_reg <= PMC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// clock and trigger drive, awake watch
	// ----------------------------------------
	// sensor lets go of a pin two edges after its write; driving earlier would fight it
	assign pins_free = (state_reg == PMC_IDLE) && !busy_o;

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			clk_div_reg <= 8'h00;
			bus.pin_one_host    <= 1'b0;
			bus.pin_one_host_oe <= 1'b0;
			bus.pin_two_host    <= 1'b0;
			bus.pin_two_host_oe <= 1'b0;
			awake_meta <= 1'b0;
			awake_sync <= 1'b0;
		end else if (clk_en_i) begin
			clk_div_reg <= clk_div_reg + 8'h01;
			// host clock and trigger are simple divider taps; pins only driven once selected
			bus.pin_one_host_oe <= (cmd_reg == pmc_pkg::CMD_EXTCLK) && pins_free;
			bus.pin_one_host    <= clk_div_reg[3];
			bus.pin_two_host_oe <= (cmd_reg == pmc_pkg::CMD_EXTTRIG) && pins_free;
			bus.pin_two_host    <= clk_div_reg[7];
			awake_meta <= bus.pin_two;
			awake_sync <= awake_meta;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
			busy_o  <= 1'b0;
		end else if (clk_en_i) begin
			busy_o  <= (state_reg == PMC_SEQ);
			rdata_o <= 8'h00;
			if (re_i) begin
				case (addr_i)
					pmc_pkg::HOST_CMD:    rdata_o <= {6'h00, cmd_reg};
					pmc_pkg::HOST_STATUS: rdata_o <= {6'h00, awake_sync, state_reg == PMC_SEQ};
					pmc_pkg::HOST_WADDR:  rdata_o <= waddr_reg;
					pmc_pkg::HOST_WDATA:  rdata_o <= wdata_reg;
					default:              rdata_o <= 8'h00;
				endcase
			end
		end
	end
endmodule // pmc_host

// *** core/pmc_if.sv ***
// interface: configuration write port and the two interrupt pins between host and sensor
interface pmc_if;
	logic       cfg_we;
	logic [7:0] cfg_addr;
	logic [7:0] cfg_wdata;
	logic       pin_one_o;
	logic       pin_one_oe;
	logic       pin_one_host;
	logic       pin_one_host_oe;
	logic       pin_two_o;
	logic       pin_two_oe;
	logic       pin_two_host;
	logic       pin_two_host_oe;
	logic       pin_one;
	logic       pin_two;

	// wire level resolved from the enables, default low when undriven
	assign pin_one = pin_one_oe ? pin_one_o : (pin_one_host_oe ? pin_one_host : 1'b0);
	assign pin_two = pin_two_oe ? pin_two_o : (pin_two_host_oe ? pin_two_host : 1'b0);

	modport sensor (
		input  cfg_we, cfg_addr, cfg_wdata, pin_one, pin_two,
		output pin_one_o, pin_one_oe, pin_two_o, pin_two_oe
	);
	modport host (
		output cfg_we, cfg_addr, cfg_wdata, pin_one_host, pin_one_host_oe, pin_two_host, pin_two_host_oe,
		input  pin_one, pin_two
	);
endinterface : pmc_if

// *** core/pmc_pkg.sv ***
// package: register map, field positions and timing constants for power mode control
package pmc_pkg;
	localparam logic [7:0] ADDR_THRESH_ACT_LOW  = 8'h20;
	localparam logic [7:0] ADDR_THRESH_ACT_HIGH = 8'h21;
	localparam logic [7:0] ADDR_ACTIVITY_TIME_COUNT        = 8'h22;
	localparam logic [7:0] ADDR_TIME_INACT      = 8'h25;
	localparam logic [7:0] ADDR_MOTION_DETECT   = 8'h27;
	localparam logic [7:0] ADDR_IRQ_MAP_ONE     = 8'h2A;
	localparam logic [7:0] ADDR_IRQ_MAP_TWO     = 8'h2B;
	localparam logic [7:0] ADDR_RANGE_RATE      = 8'h2C;
	localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h2D;
	localparam logic [7:0] ADDR_FORCE_CHECK     = 8'h2E;

	localparam int POS_EXT_TIMEBASE  = 6;
	localparam int POS_NOISE_LSB     = 4;
	localparam int POS_DUTY_CYCLED_SLEEP_BIT        = 3;
	localparam int POS_AUTOSLEEP     = 2;
	localparam int POS_RUN_LSB       = 0;
	localparam int POS_FORCE_APPLY   = 0;
	localparam int POS_MAP_AWAKE     = 6;
	localparam int POS_MAP_ACT_LOW   = 7;
	localparam int POS_EXT_TRIGGER   = 3;
	localparam int POS_LINK_LSB      = 4;

	localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
	localparam logic [7:0] RST_FORCE_CHECK   = 8'h00;
	localparam logic [7:0] RST_IRQ_MAP       = 8'h00;
	localparam logic [7:0] RST_RANGE_RATE    = 8'h13;
	localparam logic [7:0] RST_MOTION_DETECT = 8'h00;

	localparam logic [1:0] RUN_STANDBY  = 2'h0;
	localparam logic [1:0] RUN_RUN_MODE_SELECT  = 2'h2;
	localparam logic [1:0] NOISE_NORMAL = 2'h0;
	localparam logic [1:0] NOISE_LOW    = 2'h1;
	localparam logic [1:0] NOISE_ULTRA  = 2'h2;
	localparam logic [1:0] LINK_DEFAULT = 2'h0;

	// motion switch setup values, then external clock and trigger setup values
	localparam logic [7:0] MS_THRESH_ACT_LOW = 8'hFA;
	localparam logic [7:0] MS_THRESH_ZERO    = 8'h00;
	localparam logic [7:0] MS_ACTIVITY_TIME_COUNT       = 8'h02;
	localparam logic [7:0] MS_TIME_INACT     = 8'h1E;
	localparam logic [7:0] MS_MOTION_DETECT  = 8'h3F;
	localparam logic [7:0] MS_IRQ_MAP_TWO    = 8'h40;
	localparam logic [7:0] MS_POWER_CONTROL  = 8'h0A;
	localparam logic [7:0] EXT_CLOCK_START   = 8'h42;
	localparam logic [7:0] EXT_TRIGGER_SETUP = 8'h4B;

	// host command register offsets and command codes
	localparam logic [3:0] HOST_CMD    = 4'h0;
	localparam logic [3:0] HOST_STATUS = 4'h1;
	localparam logic [3:0] HOST_WADDR  = 4'h2;
	localparam logic [3:0] HOST_WDATA  = 4'h3;
	localparam logic [1:0] CMD_SINGLE  = 2'h0;
	localparam logic [1:0] CMD_SWITCH  = 2'h1;
	localparam logic [1:0] CMD_EXTCLK  = 2'h2;
	localparam logic [1:0] CMD_EXTTRIG = 2'h3;
endpackage : pmc_pkg

// *** core/pmc_sensor.sv ***
// sensor end: power control, force check, interrupt maps and timing source selection
//
// Decided for this implementation: strobed register access.
module pmc_sensor (
	input  wire logic  ref_clk_i,
	input  wire logic  nrst_i,
	input  wire logic  clk_en_i,
	pmc_if.sensor      bus,
	input  wire logic  activity_i,
	input  wire logic  inactivity_i,
	input  wire logic  internal_tick_i,
	output logic [7:0] power_control_o,
	output logic [7:0] force_check_o,
	output logic [2:0] axis_force_o,
	output logic       measuring_o,
	output logic       duty_cycled_sleep_bit_mode_o,
	output logic [1:0] noise_mode_o,
	output logic       awake_o,
	output logic       sample_strobe_o,
	output logic       ext_timebase_o
);
	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic [7:0] power_control_reg;
	logic [7:0] force_check_reg;
	logic [7:0] irq_map_one_reg;
	logic [7:0] irq_map_two_reg;
	logic [7:0] range_rate_reg;
	logic [7:0] motion_detect_reg;
	logic       auto_wake_reg;
	logic       awake_reg;
	logic       sample_reg;
	logic       one_rise;
	logic       two_rise;
	logic       run_run_mode_select;
	logic [1:0] noise_code;
	logic       ext_timebase_select;
	logic       external_trigger_select;
	logic       autosleep_effective;
	logic       timing_tick;

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			power_control_reg <= pmc_pkg::RST_POWER_CONTROL;
			force_check_reg   <= pmc_pkg::RST_FORCE_CHECK;
			irq_map_one_reg   <= pmc_pkg::RST_IRQ_MAP;
			irq_map_two_reg   <= pmc_pkg::RST_IRQ_MAP;
			range_rate_reg    <= pmc_pkg::RST_RANGE_RATE;
			motion_detect_reg <= pmc_pkg::RST_MOTION_DETECT;
		end else if (clk_en_i && bus.cfg_we) begin
			case (bus.cfg_addr)
				pmc_pkg::ADDR_POWER_CONTROL: power_control_reg <= bus.cfg_wdata;
				pmc_pkg::ADDR_FORCE_CHECK:   force_check_reg   <= bus.cfg_wdata;
				pmc_pkg::ADDR_IRQ_MAP_ONE:   irq_map_one_reg   <= bus.cfg_wdata;
				pmc_pkg::ADDR_IRQ_MAP_TWO:   irq_map_two_reg   <= bus.cfg_wdata;
				pmc_pkg::ADDR_RANGE_RATE:    range_rate_reg    <= bus.cfg_wdata;
				pmc_pkg::ADDR_MOTION_DETECT: motion_detect_reg <= bus.cfg_wdata;
				default: begin
				end
			endcase
		end
	end

	assign ext_timebase_select     = power_control_reg[pmc_pkg::POS_EXT_TIMEBASE];
	assign external_trigger_select = range_rate_reg[pmc_pkg::POS_EXT_TRIGGER];
	// link/loop field nonzero means linked or loop mode
	assign autosleep_effective = power_control_reg[pmc_pkg::POS_AUTOSLEEP]
		&& (motion_detect_reg[pmc_pkg::POS_LINK_LSB +: 2] != pmc_pkg::LINK_DEFAULT);
	assign run_run_mode_select = power_control_reg[pmc_pkg::POS_RUN_LSB +: 2] == pmc_pkg::RUN_RUN_MODE_SELECT;

	// reserved noise code falls back to normal so no undefined mode leaks out
	always_comb begin
		noise_code = power_control_reg[pmc_pkg::POS_NOISE_LSB +: 2];
		if (noise_code == 2'h3) begin
			noise_code = pmc_pkg::NOISE_NORMAL;
		end
	end

	// ----------------------------------------
	// pin inputs
	// ----------------------------------------
	pmc_sync u_sync_one (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.en_i      (clk_en_i),
		.d_i       (bus.pin_one),
		.q_o       (),
		.rise_o    (one_rise)
	);

	pmc_sync u_sync_two (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.en_i      (clk_en_i),
		.d_i       (bus.pin_two),
		.q_o       (),
		.rise_o    (two_rise)
	);

	// external edges replace the internal tick as the timebase
	assign timing_tick = ext_timebase_select ? one_rise : internal_tick_i;

	// ----------------------------------------
	// awake state and autosleep
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			awake_reg     <= 1'b0;
			auto_wake_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (!run_run_mode_select) begin
				awake_reg     <= 1'b0;
				auto_wake_reg <= 1'b0;
			end else if (timing_tick) begin
				// activity wins when both are seen in one sample
				if (activity_i) begin
					awake_reg     <= 1'b1;
					auto_wake_reg <= 1'b0;
				end else if (inactivity_i) begin
					awake_reg     <= 1'b0;
					auto_wake_reg <= autosleep_effective;
				end
			end
		end
	end

	// ----------------------------------------
	// sample strobe and outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			sample_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (run_run_mode_select) begin
				sample_reg <= external_trigger_select ? two_rise : timing_tick;
			end else begin
				sample_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			power_control_o <= pmc_pkg::RST_POWER_CONTROL;
			force_check_o   <= pmc_pkg::RST_FORCE_CHECK;
			axis_force_o    <= 3'h0;
			measuring_o     <= 1'b0;
			duty_cycled_sleep_bit_mode_o   <= 1'b0;
			noise_mode_o    <= pmc_pkg::NOISE_NORMAL;
			awake_o         <= 1'b0;
			sample_strobe_o <= 1'b0;
			ext_timebase_o  <= 1'b0;
		end else if (clk_en_i) begin
			power_control_o <= power_control_reg;
			force_check_o   <= force_check_reg;
			axis_force_o    <= {3{force_check_reg[pmc_pkg::POS_FORCE_APPLY]}};
			measuring_o     <= run_run_mode_select;
			duty_cycled_sleep_bit_mode_o   <= power_control_reg[pmc_pkg::POS_DUTY_CYCLED_SLEEP_BIT] | auto_wake_reg;
			noise_mode_o    <= noise_code;
			awake_o         <= awake_reg;
			sample_strobe_o <= sample_reg;
			ext_timebase_o  <= ext_timebase_select;
		end
	end

	// ----------------------------------------
	// interrupt pin drive
	// ----------------------------------------
	// pin one becomes a clock input, pin two a trigger input, when selected
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			bus.pin_one_o  <= 1'b0;
			bus.pin_one_oe <= 1'b0;
			bus.pin_two_o  <= 1'b0;
			bus.pin_two_oe <= 1'b0;
		end else if (clk_en_i) begin
			bus.pin_one_oe <= !ext_timebase_select && irq_map_one_reg[pmc_pkg::POS_MAP_AWAKE];
			bus.pin_one_o  <= (irq_map_one_reg[pmc_pkg::POS_MAP_AWAKE] & awake_reg)
				^ irq_map_one_reg[pmc_pkg::POS_MAP_ACT_LOW];
			bus.pin_two_oe <= !external_trigger_select && irq_map_two_reg[pmc_pkg::POS_MAP_AWAKE];
			bus.pin_two_o  <= (irq_map_two_reg[pmc_pkg::POS_MAP_AWAKE] & awake_reg)
				^ irq_map_two_reg[pmc_pkg::POS_MAP_ACT_LOW];
		end
	end
endmodule // pmc_sensor

// *** core/pmc_sync.sv ***
// two-flop synchroniser with edge pulse taken from the settled copy
module pmc_sync (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic en_i,
	input  wire logic d_i,
	output logic      q_o,
	output logic      rise_o
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else if (en_i) begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign q_o    = sync_reg;
	assign rise_o = sync_reg & ~last_reg;
endmodule // pmc_sync

// *** verif/pmc_monitor.sv ***
// checker: assertions on the configuration link and the two interrupt pins
module pmc_monitor (
	input wire logic       ref_clk_i,
	input wire logic       nrst_i,
	input wire logic       cfg_we,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic       pin_one_oe,
	input wire logic       pin_one_host_oe,
	input wire logic       pin_two,
	input wire logic       pin_two_oe,
	input wire logic       pin_two_host_oe
);
	// ----
	// link properties
	// ----
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence wr(logic [7:0] a, logic [7:0] d);
		cfg_we && cfg_addr == a && cfg_wdata == d;
	endsequence

	a_order_ascending: assert property (cfg_we && $past(cfg_we) |-> cfg_addr > $past(cfg_addr))
		else $error("config writes out of address order");
	a_activity_time_count_big: assert property (cfg_we && cfg_addr == pmc_pkg::ADDR_ACTIVITY_TIME_COUNT |-> cfg_wdata > 8'h01)
		else $error("activity time count too small");
	a_thresh_high_zero: assert property (wr(pmc_pkg::ADDR_THRESH_ACT_LOW, pmc_pkg::MS_THRESH_ACT_LOW) |=>
		wr(pmc_pkg::ADDR_THRESH_ACT_HIGH, 8'h00)) else $error("threshold high byte not zero");
	a_inact_timer: assert property (cfg_we && cfg_addr == pmc_pkg::ADDR_ACTIVITY_TIME_COUNT |=>
		wr(pmc_pkg::ADDR_TIME_INACT, pmc_pkg::MS_TIME_INACT)) else $error("inactivity timer wrong");
	a_motion_loop: assert property (cfg_we && cfg_addr == pmc_pkg::ADDR_TIME_INACT |=>
		wr(pmc_pkg::ADDR_MOTION_DETECT, pmc_pkg::MS_MOTION_DETECT)) else $error("motion detect wrong");
	a_map_awake: assert property (wr(pmc_pkg::ADDR_MOTION_DETECT, pmc_pkg::MS_MOTION_DETECT) |=>
		wr(pmc_pkg::ADDR_IRQ_MAP_TWO, pmc_pkg::MS_IRQ_MAP_TWO)) else $error("pin two map wrong");
	a_power_last: assert property (wr(pmc_pkg::ADDR_IRQ_MAP_TWO, pmc_pkg::MS_IRQ_MAP_TWO) |=>
		wr(pmc_pkg::ADDR_POWER_CONTROL, pmc_pkg::MS_POWER_CONTROL) ##1 !cfg_we) else $error("switch end wrong");
	a_no_reserved: assert property (cfg_we && cfg_addr == pmc_pkg::ADDR_POWER_CONTROL |->
		cfg_wdata[5:4] != 2'h3 && !cfg_wdata[0]) else $error("reserved power code written");
	a_external_timebase_select_drive: assert property (wr(pmc_pkg::ADDR_POWER_CONTROL, pmc_pkg::EXT_CLOCK_START) |->
		##[1:32] pin_one_host_oe) else $error("external clock not driven");
	a_clock_pin_in: assert property (pin_one_host_oe |-> !pin_one_oe)
		else $error("sensor drives clock pin");
	a_trig_pin_in: assert property (pin_two_host_oe |-> !pin_two_oe)
		else $error("sensor drives trigger pin");

	c_switch: cover property (wr(pmc_pkg::ADDR_POWER_CONTROL, pmc_pkg::MS_POWER_CONTROL));
	c_clock: cover property (pin_one_host_oe);
	c_trigger: cover property (pin_two_host_oe);
	c_awake: cover property (pin_two_oe && pin_two);
endmodule // pmc_monitor

// *** verif/tb_power_mode_control.sv ***
// testbench: both ends joined, single-write commands with random values plus corner cases
module tb_power_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk_i, nrst_i, act_i, inact_i, tick_i, we_i, re_i, busy_o;
	logic       measuring_o, duty_cycled_sleep_bit_mode_o, awake_o, sample_strobe_o, ext_timebase_o;
	logic [1:0] noise_mode_o;
	logic [2:0] axis_force_o;
	logic [3:0] addr_i;
	logic [7:0] wdata_i, rdata_o, power_control_o, force_check_o;
	int         num_errors = 0;
	int         comparisons = 0;

	pmc_if u_pmc_if ();
	pmc_sensor u_pmc_sensor (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .bus(u_pmc_if),
		.activity_i(act_i), .inactivity_i(inact_i), .internal_tick_i(tick_i),
		.power_control_o(power_control_o), .force_check_o(force_check_o), .axis_force_o(axis_force_o),
		.measuring_o(measuring_o), .duty_cycled_sleep_bit_mode_o(duty_cycled_sleep_bit_mode_o), .noise_mode_o(noise_mode_o),
		.awake_o(awake_o), .sample_strobe_o(sample_strobe_o), .ext_timebase_o(ext_timebase_o));
	pmc_host u_pmc_host (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .bus(u_pmc_if),
		.addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .busy_o(busy_o));
	pmc_monitor u_pmc_monitor (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cfg_we(u_pmc_if.cfg_we),
		.cfg_addr(u_pmc_if.cfg_addr), .cfg_wdata(u_pmc_if.cfg_wdata), .pin_one_oe(u_pmc_if.pin_one_oe),
		.pin_one_host_oe(u_pmc_if.pin_one_host_oe), .pin_two(u_pmc_if.pin_two),
		.pin_two_oe(u_pmc_if.pin_two_oe), .pin_two_host_oe(u_pmc_if.pin_two_host_oe));

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// ----
	// helpers
	// ----
	task automatic results();
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic sw(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge ref_clk_i);
		we_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge ref_clk_i);
		re_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	// busy must clear in bounded time, else the run ends
	task automatic cmd(input logic [1:0] c, input logic [7:0] a, input logic [7:0] d);
		int i;
		sw(pmc_pkg::HOST_WADDR, a);
		sw(pmc_pkg::HOST_WDATA, d);
		sw(pmc_pkg::HOST_CMD, {6'h00, c});
		wt(2);
		for (i = 0; i < 64 && busy_o !== 1'b0; i++) wt(1);
		if (i == 64) begin
			num_errors++;
			$display("BAD %0t busy stuck", $time);
			results();
		end
		wt(4);
	endtask

	task automatic tick(input logic a, input logic n);
		@(posedge ref_clk_i);
		act_i <= a;
		inact_i <= n;
		tick_i <= 1'b1;
		@(posedge ref_clk_i);
		tick_i <= 1'b0;
		wt(6);
	endtask

	task automatic cnt(input int n, output int s, output int r1, output int r2);
		logic p1;
		logic p2;
		s = 0;
		r1 = 0;
		r2 = 0;
		p1 = u_pmc_if.pin_one;
		p2 = u_pmc_if.pin_two;
		repeat (n) begin
			wt(1);
			if (sample_strobe_o === 1'b1) s++;
			if (u_pmc_if.pin_one === 1'b1 && p1 === 1'b0) r1++;
			if (u_pmc_if.pin_two === 1'b1 && p2 === 1'b0) r2++;
			p1 = u_pmc_if.pin_one;
			p2 = u_pmc_if.pin_two;
		end
	endtask

	// legal power value: reserved codes folded away, external clock kept off
	function automatic logic [7:0] legal_power(input logic [31:0] r);
		return {2'b00, (r[5:4] == 2'h3) ? 2'h0 : r[5:4], r[3:2], r[1], 1'b0};
	endfunction

	function automatic logic near(input int a, input int b);
		return a <= b + 1 && b <= a + 1;
	endfunction

	// ----
	// main sequence
	// ----
	initial begin
		logic [7:0] d, e;
		int         s, r1, r2;
		nrst_i = 1'b0;
		act_i = 1'b0;
		inact_i = 1'b0;
		tick_i = 1'b0;
		we_i = 1'b0;
		re_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 8'h00;
		void'($urandom(67138));
		repeat (12) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		wt(1);
		chk(power_control_o, pmc_pkg::RST_POWER_CONTROL, "power reset");
		chk(force_check_o, pmc_pkg::RST_FORCE_CHECK, "force reset");
		for (int k = 0; k < 6; k++) begin
			d = 8'($urandom());
			cmd(pmc_pkg::CMD_SINGLE, pmc_pkg::ADDR_FORCE_CHECK, d);
			chk(force_check_o, d, "force copy");
			chk({5'h00, axis_force_o}, {5'h00, {3{d[0]}}}, "axis force");
			e = legal_power(($urandom() & 32'hFFFFFFCD) | ((k % 3) << 4) | ((k % 2) << 1));
			cmd(pmc_pkg::CMD_SINGLE, pmc_pkg::ADDR_POWER_CONTROL, e);
			tick(1'b0, 1'b1);
			chk(power_control_o, e, "power copy");
			chk({7'h00, measuring_o}, {7'h00, e[1]}, "run mode");
			chk({6'h00, noise_mode_o}, {6'h00, e[5:4]}, "noise mode");
			chk({7'h00, duty_cycled_sleep_bit_mode_o}, {7'h00, e[3]}, "wake-up bit");
			chk({7'h00, ext_timebase_o}, 8'h00, "internal timebase");
		end
		sw(4'hF, 8'hFF);
		wt(4);
		chk(power_control_o, e, "unmapped write");
		cmd(pmc_pkg::CMD_SWITCH, 8'h00, 8'h00);
		chk(power_control_o, pmc_pkg::MS_POWER_CONTROL, "switch power");
		chk({7'h00, duty_cycled_sleep_bit_mode_o}, 8'h01, "switch wake-up");
		tick(1'b1, 1'b0);
		chk({7'h00, awake_o}, 8'h01, "awake");
		chk({7'h00, u_pmc_if.pin_two}, 8'h01, "awake on pin two");
		rd(pmc_pkg::HOST_STATUS, d);
		chk({6'h00, d[1:0]}, 8'h02, "status awake");
		cmd(pmc_pkg::CMD_SINGLE, pmc_pkg::ADDR_IRQ_MAP_TWO, 8'hC0);
		chk({7'h00, u_pmc_if.pin_two}, 8'h00, "active low awake");
		tick(1'b0, 1'b1);
		chk({7'h00, awake_o}, 8'h00, "asleep");
		chk({7'h00, u_pmc_if.pin_two}, 8'h01, "active low asleep");
		cmd(pmc_pkg::CMD_SINGLE, pmc_pkg::ADDR_POWER_CONTROL, 8'h06);
		chk({7'h00, duty_cycled_sleep_bit_mode_o}, 8'h00, "no wake-up yet");
		tick(1'b0, 1'b1);
		chk({7'h00, duty_cycled_sleep_bit_mode_o}, 8'h01, "autosleep entry");
		tick(1'b1, 1'b0);
		chk({7'h00, duty_cycled_sleep_bit_mode_o}, 8'h00, "activity wakes");
		cmd(pmc_pkg::CMD_SINGLE, pmc_pkg::ADDR_IRQ_MAP_ONE, 8'h40);
		chk({7'h00, u_pmc_if.pin_one}, 8'h01, "awake on pin one");
		cmd(pmc_pkg::CMD_EXTCLK, 8'h00, 8'h00);
		chk(power_control_o, pmc_pkg::EXT_CLOCK_START, "external clock start");
		chk({7'h00, ext_timebase_o}, 8'h01, "external timebase");
		cnt(320, s, r1, r2);
		chk({7'h00, near(r1, 20)}, 8'h01, "clock rate on pin one");
		chk({7'h00, near(s, r1)}, 8'h01, "sample per clock");
		cmd(pmc_pkg::CMD_EXTTRIG, 8'h00, 8'h00);
		cnt(1024, s, r1, r2);
		chk({7'h00, near(r2, 4)}, 8'h01, "trigger rate on pin two");
		chk({7'h00, near(s, r2)}, 8'h01, "sample per trigger");
		results();
	end
endmodule // tb_power_mode_control
